// *** hw/power_mode_reset_control.v ***
// Behaviour
// - Halt bit write stops CPU clock after instruction; peripheral clocks keep running.
// - During halt, registers and memory hold their contents.
// - Halt ends on an enabled interrupt or the reset pin.
// - Interrupt wake clears halt bit, resumes CPU, services interrupt, then continues.
// - Reset ending halt runs the normal sequence from address zero.
// - Enabled watchdog overflow during halt gives a reset that ends it.
// - Stop bit write halts CPU and oscillators after the instruction.
// - In stop, interrupts and timers are off except the lost-clock detector.
// - Only a reset ends stop; then normal sequence from address zero.
// - Enabled lost-clock detector resets out of stop after its timeout.
// - Mode bits read zero, zero writes do nothing, upper bits reserved.
// - Entering reset halts execution, resets registers, pins, interrupts and timers.
// - Reset keeps data memory; stack pointer is still reinitialized.
// - Reset sets all port latches to ones.
// - Leaving reset clears PC, picks slow internal oscillator, waits for stable clock.
// - After any reset the watchdog is enabled with longest interval.
// - Seven reset causes are accepted.
// - Supply monitor holds reset and drives pin low until timeout at power-on, later only while supply is low; pin enables it.
//   The code ends the power-on hold one clock after sys_rst, as men_s_r resets to zero.
// - Power-on sets its flag; every other cause clears it.
// - After pin release, stay in reset twelve cycles, then set pin flag.
// - Lost-clock timeout resets, sets its flag, leaves reset pin undriven.
`timescale 1ns/100ps
`include "pmrc_regs.vh"
module power_mode_reset_control #(
  parameter MON_CYC = `MON_TIMEOUT_CYC,
  parameter MCD_CYC = `MCD_TIMEOUT_CYC
) (
  input  wire       clock,
  input  wire       sys_rst,
  input  wire       rst_pin_n_i,
  output reg        rst_pin_o,
  output reg        rst_pin_oe,
  input  wire       supply_ok,
  input  wire       supply_monitor_enable_pin,
  input  wire       convert_start_input,
  input  wire       comparator_trip_n,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  input  wire       instr_done,
  input  wire       irq_pending,
  input  wire       clock_present,
  input  wire       wdt_overflow,
  input  wire       wdt_enabled,
  input  wire       mcd_enable,
  input  wire       cnv_reset_en,
  input  wire       cmp_reset_en,
  input  wire       sw_reset,
  input  wire       osc_stable,
  output reg        core_reset,
  output reg        cpu_clk_en,
  output reg        periph_clk_en,
  output reg        osc_en,
  output reg        irq_service,
  output reg        irq_timer_en,
  output reg        sp_reinit,
  output reg  [7:0] port_latch_init,
  output reg  [15:0] pc_start,
  output reg        osc_slow_sel,
  output reg        wdt_force_enable,
  output reg  [2:0] wdt_interval,
  output reg  [7:0] reset_cause_reg
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_RUN     = 3'h0;
  localparam ST_HALT    = 3'h1;
  localparam ST_STOP    = 3'h2;
  localparam ST_RESET   = 3'h3;
  localparam ST_STRETCH = 3'h4;
  localparam ST_WAITOSC = 3'h5;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] pin_s_r;
  reg [1:0] sup_s_r;
  reg [1:0] men_s_r;
  reg [1:0] cnv_s_r;
  reg [1:0] cmp_s_r;
  reg [1:0] clk_s_r;

  // Every external level passes two flops; only bit 1 is read.
  always @(posedge clock) begin
    if (sys_rst) begin
      pin_s_r <= 2'h3;
      sup_s_r <= 2'h0;
      men_s_r <= 2'h0;
      cnv_s_r <= 2'h3;
      cmp_s_r <= 2'h3;
      clk_s_r <= 2'h3;
    end else begin
      pin_s_r <= {pin_s_r[0], rst_pin_n_i};
      sup_s_r <= {sup_s_r[0], supply_ok};
      men_s_r <= {men_s_r[0], supply_monitor_enable_pin};
      cnv_s_r <= {cnv_s_r[0], convert_start_input};
      cmp_s_r <= {cmp_s_r[0], comparator_trip_n};
      clk_s_r <= {clk_s_r[0], clock_present};
    end
  end

  wire pin_low = ~pin_s_r[1];
  wire sup_low = men_s_r[1] & ~sup_s_r[1];

  // ----------------------------------------
  // Pin echo mask
  // ----------------------------------------
  // Our own monitor drive comes back on the pin through the two synchroniser flops.
  // Masking that echo stops a power-on reset from being logged as a pin reset,
  // at the cost of ignoring a real pin press in the two cycles after release.
  reg [1:0] oe_hist_r;

  always @(posedge clock) begin
    if (sys_rst) begin
      oe_hist_r <= 2'h3;
    end else begin
      oe_hist_r <= {oe_hist_r[0], rst_pin_oe};
    end
  end

  wire pin_echo = rst_pin_oe | (|oe_hist_r);
  wire pin_ext  = pin_low & ~pin_echo;

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [31:0] cnt_r;
  reg [31:0] mcd_cnt_r;
  reg        por_done_r;
  reg        pin_cause_r;
  reg        stop_r;

  // A missing clock is modelled as a sampled absence; the counter measures it.
  // lost-clock timeout
  wire mcd_trip = mcd_enable & (mcd_cnt_r >= MCD_CYC);

  always @(posedge clock) begin
    if (sys_rst | clk_s_r[1]) begin
      mcd_cnt_r <= 32'h0;
    end else if (~mcd_trip) begin
      mcd_cnt_r <= mcd_cnt_r + 32'h1;
    end
  end

  // Watchdog counts only while CPU halted or running; stopped clocks freeze it.
  // watchdog wakes halt
  wire wdt_trip = wdt_enabled & wdt_overflow & ~stop_r;
  wire cnv_trip = cnv_reset_en & ~cnv_s_r[1] & ~stop_r;
  wire cmp_trip = cmp_reset_en & ~cmp_s_r[1] & ~stop_r;
  wire sw_trip  = sw_reset & ~stop_r;
  wire int_trip = wdt_trip | cnv_trip | cmp_trip | sw_trip | mcd_trip;
  wire any_rst  = int_trip | pin_low | sup_low | ~por_done_r;

  // Power control write decode; zero bits ignored.
  // write one only
  wire pwr_wr   = sfr_wr & (sfr_addr == `PWR_CTRL_ADDR);
  wire stop_req = pwr_wr & sfr_wdata[`PWR_STOP_BIT];
  wire halt_req = pwr_wr & sfr_wdata[`PWR_HALT_BIT];

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (any_rst) begin
          state_nxt = ST_RESET;
        end else if (stop_req & instr_done) begin
          state_nxt = ST_STOP;
        end else if (halt_req & instr_done) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (any_rst) begin
          state_nxt = ST_RESET;
        end else if (irq_pending) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STOP: begin
        if (any_rst) begin
          state_nxt = ST_RESET;
        end
      end
      ST_RESET: begin
        if (~any_rst) begin
          state_nxt = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        if (any_rst) begin
          state_nxt = ST_RESET;
        end else if (cnt_r >= (`PIN_STRETCH_CYC - 1)) begin
          state_nxt = ST_WAITOSC;
        end
      end
      ST_WAITOSC: begin
        if (any_rst) begin
          state_nxt = ST_RESET;
        end else if (osc_stable & (cnt_r >= (`STABLE_CYC - 1))) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  // The power-on count ends on the first clock after sys_rst, as men_s_r resets to zero.
  // monitor timeout
  always @(posedge clock) begin
    if (sys_rst) begin
      state_r     <= ST_RESET;
      cnt_r       <= 32'h0;
      por_done_r  <= 1'b0;
      pin_cause_r <= 1'b0;
      stop_r      <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stop_r  <= (state_nxt == ST_STOP);
      if (~por_done_r) begin
        if (~men_s_r[1] | (cnt_r >= (MON_CYC - 1))) begin
          por_done_r <= 1'b1;
          cnt_r      <= 32'h0;
        end else if (sup_s_r[1]) begin
          cnt_r <= cnt_r + 32'h1;
        end else begin
          cnt_r <= 32'h0;
        end
      end else if (state_nxt != state_r) begin
        cnt_r <= 32'h0;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
      // The pin cause is sticky through the whole reset, since the pin is gone by its end.
      if (state_r == ST_RESET) begin
        pin_cause_r <= pin_cause_r | pin_ext;
      end else if (state_r == ST_RUN) begin
        pin_cause_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Reset cause flags
  // ----------------------------------------
  // Flags latch while in reset; the pin flag is posted only at stretch end.
  always @(posedge clock) begin
    if (sys_rst) begin
      reset_cause_reg <= `CAUSE_POR_RESET;
    end else if (any_rst) begin
      // A fresh reset out of normal operation forgets the previous cause.
      if ((state_r == ST_RUN) | (state_r == ST_HALT) | (state_r == ST_STOP)) begin
        reset_cause_reg[6:2] <= 5'h00;
      end
      // Only a real cause clears the power-on flag, not our own pin echo.
      if (~por_done_r | sup_low) begin
        reset_cause_reg[`CAUSE_POR_BIT] <= 1'b1;
      end else if (int_trip | pin_ext) begin
        reset_cause_reg[`CAUSE_POR_BIT] <= 1'b0;
      end
      reset_cause_reg[`CAUSE_PIN_BIT] <= 1'b0;
      if (mcd_trip) reset_cause_reg[`CAUSE_MCD_BIT] <= 1'b1;
      if (wdt_trip) reset_cause_reg[`CAUSE_WDT_BIT] <= 1'b1;
      if (sw_trip)  reset_cause_reg[`CAUSE_SW_BIT]  <= 1'b1;
      if (cmp_trip) reset_cause_reg[`CAUSE_CMP_BIT] <= 1'b1;
      if (cnv_trip) reset_cause_reg[`CAUSE_CNV_BIT] <= 1'b1;
    end else if ((state_r == ST_STRETCH) & (state_nxt == ST_WAITOSC) & pin_cause_r) begin
      reset_cause_reg[`CAUSE_PIN_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // reset state effects
  always @(posedge clock) begin
    if (sys_rst) begin
      rst_pin_o        <= 1'b0;
      rst_pin_oe       <= 1'b1;
      core_reset       <= 1'b1;
      cpu_clk_en       <= 1'b0;
      periph_clk_en    <= 1'b0;
      osc_en           <= 1'b1;
      irq_service      <= 1'b0;
      irq_timer_en     <= 1'b0;
      sp_reinit        <= 1'b1;
      port_latch_init  <= `PORT_LATCH_RESET;
      pc_start         <= `RESET_VECTOR;
      osc_slow_sel     <= 1'b1;
      wdt_force_enable <= 1'b1;
      wdt_interval     <= `WDT_INTERVAL_RESET;
      sfr_rdata        <= 8'h00;
    end else begin
      rst_pin_o <= 1'b0;
      rst_pin_oe <= ~por_done_r | sup_low;
      core_reset <= (state_nxt == ST_RESET) | (state_nxt == ST_STRETCH) | (state_nxt == ST_WAITOSC);
      cpu_clk_en    <= (state_nxt == ST_RUN);
      periph_clk_en <= (state_nxt == ST_RUN) | (state_nxt == ST_HALT);
      osc_en        <= (state_nxt != ST_STOP);
      irq_service  <= (state_r == ST_HALT) & (state_nxt == ST_RUN);
      irq_timer_en <= (state_nxt == ST_RUN) | (state_nxt == ST_HALT);
      sp_reinit    <= (state_nxt == ST_RESET);
      port_latch_init  <= `PORT_LATCH_RESET;
      pc_start         <= `RESET_VECTOR;
      osc_slow_sel     <= (state_nxt != ST_RUN) & (state_nxt != ST_HALT) & (state_nxt != ST_STOP);
      wdt_force_enable <= (state_nxt == ST_RESET);
      wdt_interval     <= `WDT_INTERVAL_RESET;
      if (sfr_rd & (sfr_addr == `CAUSE_ADDR)) begin
        sfr_rdata <= reset_cause_reg;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

endmodule

// *** hw/pmrc_regs.vh ***
`ifndef PMRC_REGS_VH
`define PMRC_REGS_VH
// ----------------------------------------
// Register map and field positions
// ----------------------------------------
`define PWR_CTRL_ADDR      8'h87
`define PWR_CTRL_RESET     8'h00
`define PWR_HALT_BIT       0
`define PWR_STOP_BIT       1
`define CAUSE_ADDR         8'hEF
`define CAUSE_PIN_BIT      0
`define CAUSE_POR_BIT      1
`define CAUSE_MCD_BIT      2
`define CAUSE_WDT_BIT      3
`define CAUSE_SW_BIT       4
`define CAUSE_CMP_BIT      5
`define CAUSE_CNV_BIT      6
`define CAUSE_RESET        8'h00
`define CAUSE_POR_RESET    8'h02
`define PORT_LATCH_RESET   8'hFF
`define RESET_VECTOR       16'h0000
`define WDT_INTERVAL_RESET 3'h7
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS      10
`define PIN_STRETCH_CYC    12
`define MCD_TIMEOUT_US     100
`define MCD_TIMEOUT_CYC    ((`MCD_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define MON_TIMEOUT_MS     100
`define MON_TIMEOUT_CYC    ((`MON_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define STABLE_CYC         16
`endif

// *** sim/pmrc_assertions.sv ***
`timescale 1ns/100ps
module pmrc_assertions (
  input wire        clock,
  input wire        sys_rst,
  input wire        rst_pin_o,
  input wire        rst_pin_oe,
  input wire        sfr_wr,
  input wire        sfr_rd,
  input wire [7:0]  sfr_addr,
  input wire [7:0]  sfr_wdata,
  input wire [7:0]  sfr_rdata,
  input wire        instr_done,
  input wire        irq_pending,
  input wire        core_reset,
  input wire        cpu_clk_en,
  input wire        periph_clk_en,
  input wire        osc_en,
  input wire        irq_service,
  input wire [7:0]  port_latch_init,
  input wire [15:0] pc_start,
  input wire [2:0]  wdt_interval
);
  // ----------------------------------------
  // Mode write decode and halt tracking
  // ----------------------------------------
  // A mode write only counts while the core runs, as the core itself would see it.
  wire mode_wr = sfr_wr && instr_done && sfr_addr == 8'h87 && cpu_clk_en && !core_reset;
  reg  halted_r;
  // Remembers a pure halt entry so an interrupt wake is not confused with stop.
  always @(posedge clock) begin
    halted_r <= sys_rst ? 1'b0 : (mode_wr && sfr_wdata[1:0] == 2'b01) ? 1'b1 :
                (cpu_clk_en || core_reset) ? 1'b0 : halted_r;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  halt_entry_a: assert property (mode_wr && sfr_wdata[1:0] == 2'b01 |=> !cpu_clk_en && periph_clk_en && osc_en)
    else $error("halt entry wrong");
  stop_entry_a: assert property (mode_wr && sfr_wdata[1] |=> !cpu_clk_en && !osc_en && !periph_clk_en)
    else $error("stop entry wrong");
  zero_write_a: assert property (mode_wr && sfr_wdata[1:0] == 2'b00 |=> cpu_clk_en)
    else $error("zero write acted");
  mode_read_a: assert property (sfr_rd && sfr_addr == 8'h87 |=> sfr_rdata == 8'h00)
    else $error("mode bits read nonzero");
  irq_wake_a: assert property (halted_r && !cpu_clk_en && irq_pending |=> cpu_clk_en && irq_service)
    else $error("no wake on interrupt");
  stop_hold_a: assert property (!osc_en && !core_reset && irq_pending |=> !cpu_clk_en)
    else $error("interrupt ended stop");
  reset_state_a: assert property (core_reset |-> port_latch_init == 8'hFF && pc_start == 16'h0000)
    else $error("reset state wrong");
  wdt_default_a: assert property (core_reset |-> wdt_interval == 3'h7)
    else $error("watchdog interval wrong");
  pin_low_only_a: assert property (rst_pin_oe |-> !rst_pin_o)
    else $error("reset pin driven high");
endmodule
bind power_mode_reset_control pmrc_assertions chk_u (.*);

// *** sim/ext_reset_model.sv ***
`timescale 1ns/100ps
module ext_reset_model (
  input  wire clock,
  input  wire press,
  input  wire rst_pin_o,
  input  wire rst_pin_oe,
  output wire rst_pin_n_i,
  output reg  supply_ok
);
  // ----------------------------------------
  // Reset pin and supply
  // ----------------------------------------
  // monitor pulls low
  // Open-drain pin with a pull-up: whoever pulls low wins, so an idle pin reads high.
  assign rst_pin_n_i = !(press || (rst_pin_oe && !rst_pin_o));
  // The supply rises one cycle into the run and then stays good.
  initial supply_ok = 1'b0;
  always @(posedge clock) begin
    supply_ok <= 1'b1;
  end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------
  // Stimulus, checks and scenarios
  // ----------------------------------------
  reg        clock = 1'b0;
  reg        sys_rst = 1'b1;
  reg        press = 1'b0;
  reg        sfr_wr = 1'b0;
  reg        sfr_rd = 1'b0;
  reg        instr_done = 1'b0;
  reg        irq_pending = 1'b0;
  reg        clock_present = 1'b1;
  reg        wdt_overflow = 1'b0;
  reg        sw_reset = 1'b0;
  reg        mcd_enable = 1'b0;
  reg        convert_start_input = 1'b1;
  reg        comparator_trip_n = 1'b1;
  reg        supply_monitor_enable_pin = 1'b1;
  reg        wdt_enabled = 1'b1;
  reg        cnv_reset_en = 1'b1;
  reg        cmp_reset_en = 1'b1;
  reg        osc_stable = 1'b1;
  reg  [7:0] sfr_addr = 8'h00;
  reg  [7:0] sfr_wdata = 8'h00;
  wire       rst_pin_n_i, rst_pin_o, rst_pin_oe, supply_ok, core_reset, cpu_clk_en, periph_clk_en;
  wire       osc_en, irq_service, irq_timer_en, sp_reinit, osc_slow_sel, wdt_force_enable;
  wire [7:0] sfr_rdata, port_latch_init, reset_cause_reg;
  wire [15:0] pc_start;
  wire [2:0] wdt_interval;
  integer    n_errors = 0;
  integer    total_checks = 0;
  // Short counts keep the lost-clock wait to a few dozen cycles; the power-on count ends at once.
  power_mode_reset_control #(.MON_CYC(20), .MCD_CYC(20)) dut_u (.*);
  ext_reset_model far_u (.*);
  always #5 clock = ~clock;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Waits for the core to run (sel 0) or to enter reset (sel 1), never forever.
  task wait_for(input sel);
    integer i;
    begin
      for (i = 0; i < 200 && (sel ? core_reset : cpu_clk_en) !== 1'b1; i = i + 1) begin
        @(posedge clock);
        #1;
      end
      if (i == 200) begin
        chk(1'b0, 1'b1);
        tally_and_finish;
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      sfr_wr <= 1'b1;
      instr_done <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clock);
      sfr_wr <= 1'b0;
      instr_done <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clock);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clock);
      sfr_rd <= 1'b0;
      #1;
    end
  endtask
  task pulse_edges(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task test_power_on;
    begin
      pulse_edges(2);
      sys_rst <= 1'b0;
      chk(rst_pin_oe, 1'b1);
      chk(port_latch_init, 8'hFF);
      chk(wdt_interval, 3'h7);
      wait_for(0);
      chk(reset_cause_reg[1], 1'b1);
      chk(irq_timer_en, 1'b1);
      $display("power-on done");
    end
  endtask
  task test_halt;
    begin
    wr(8'h87, 8'h01);
    chk(periph_clk_en, 1'b1);
    pulse_edges(5);
    chk(cpu_clk_en, 1'b0);
    @(posedge clock);
    irq_pending <= 1'b1;
    pulse_edges(1);
    chk(irq_service, 1'b1);
    chk(cpu_clk_en, 1'b1);
    @(posedge clock);
    irq_pending <= 1'b0;
    wr(8'h87, 8'h00);
    chk(cpu_clk_en, 1'b1);
    rd(8'h87);
    chk(sfr_rdata, 8'h00);
    $display("halt and mode bits done");
    end
  endtask
  task test_watchdog;
    begin
    wr(8'h87, 8'h01);
    @(posedge clock);
    wdt_overflow <= 1'b1;
    @(posedge clock);
    wdt_overflow <= 1'b0;
    wait_for(1);
    chk(pc_start, 16'h0000);
    wait_for(0);
    chk(reset_cause_reg[3], 1'b1);
    chk(reset_cause_reg[1], 1'b0);
    $display("watchdog done");
    end
  endtask
  task test_stop;
    begin
    @(posedge clock);
    mcd_enable <= 1'b1;
    wr(8'h87, 8'h03);
    chk(osc_en, 1'b0);
    chk(irq_timer_en, 1'b0);
    @(posedge clock);
    irq_pending <= 1'b1;
    clock_present <= 1'b0;
    pulse_edges(3);
    chk(cpu_clk_en, 1'b0);
    @(posedge clock);
    irq_pending <= 1'b0;
    wait_for(1);
    chk(rst_pin_oe, 1'b0);
    @(posedge clock);
    clock_present <= 1'b1;
    wait_for(0);
    chk(reset_cause_reg[2], 1'b1);
    $display("stop done");
    end
  endtask
  task test_pin;
    begin
    @(posedge clock);
    press <= 1'b1;
    pulse_edges(6);
    chk(core_reset, 1'b1);
    chk(irq_timer_en, 1'b0);
    chk(sp_reinit, 1'b1);
    chk(osc_slow_sel, 1'b1);
    chk(wdt_force_enable, 1'b1);
    @(posedge clock);
    press <= 1'b0;
    pulse_edges(12);
    chk(core_reset, 1'b1);
    wait_for(0);
    chk(reset_cause_reg[1:0], 2'b01);
    $display("pin reset done");
    end
  endtask
  task test_causes;
    integer k;
    begin
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge clock);
      sw_reset <= (k == 0);
      convert_start_input <= (k != 1);
      comparator_trip_n <= (k != 2);
      @(posedge clock);
      sw_reset <= 1'b0;
      wait_for(1);
      @(posedge clock);
      convert_start_input <= 1'b1;
      comparator_trip_n <= 1'b1;
      wait_for(0);
      chk(reset_cause_reg[4 + 2 * (k == 1) + (k == 2)], 1'b1);
    end
    $display("cause sources done");
    end
  endtask
  initial begin
    test_power_on;
    test_halt;
    test_watchdog;
    test_stop;
    test_pin;
    test_causes;
    tally_and_finish;
  end
endmodule
